// File: rtl/trf_map.vh
// Purpose: constants for the touch report framer
// Assumes: one system clock, synchronous active-high reset
// Notes:   frames are raw bytes, high byte of each coordinate first
//
// Overview of operation
// - Each axis position has 1024 steps, ten bits wide.
// - Upper left corner is zero; values grow rightward and downward.
// - Every report byte is raw binary, never character encoded.
// - A position report opens with header byte 11h, meaning pressed.
// - Horizontal position follows as two bytes, value 0 to 3FFh.
// - Vertical position follows as two bytes, completing a five-byte frame.
// - Each coordinate field sends its high byte first, then low byte.
// - While pressed, frames repeat even when position is unchanged.
// - Moving contact gives new coordinates without any release byte.
// - On release send one 10h byte only, then stay silent.
// - Switch on selects USB link, off selects serial port.
// - Switches are sampled only at start-up after reset.
// - No new reports start while the setup menu is active; queued bytes still leave.
`ifndef TRF_MAP_VH
`define TRF_MAP_VH
`define TRF_HDR_PRESSED   8'h11
`define TRF_HDR_RELEASED  8'h10
`define TRF_COORD_W       10
`define TRF_COORD_MAX     10'h3FF
`define TRF_FRAME_BYTES   3'h5
`define TRF_FIFO_DEPTH    16
`define TRF_BYTE_W        8
`define TRF_STRAP_DLY     4'hF
`define TRF_REL_BYTES     3'h1
`define TRF_AXES          2
`define TRF_AXIS_X        0
`define TRF_AXIS_Y        1
`define TRF_LINKS         2
`define TRF_LANE_UART     0
`define TRF_LANE_USB      1
`endif

// File: rtl/trf_fifo.v
// Purpose: byte FIFO between framer and link
// Assumes: single clock, synchronous reset
// Notes:   depth must be a power of two
module trf_fifo #(
  parameter W     = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         i_sys_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_wr_data,
  input  wire         i_wr_valid,
  output wire         o_wr_ready,
  output wire [W-1:0] o_rd_data,
  output wire         o_rd_valid,
  input  wire         i_rd_ready,
  output wire [AW:0]  o_free
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0]  wp_r;
  reg [AW:0]  rp_r;
  wire        full;
  wire        empty;
  wire        wr_en;
  wire        rd_en;
  wire [AW:0] used;

  assign used       = wp_r - rp_r;
  assign full       = (used == DEPTH[AW:0]);
  assign empty      = (wp_r == rp_r);
  assign o_wr_ready = ~full;
  assign o_rd_valid = ~empty;
  assign o_rd_data  = mem[rp_r[AW-1:0]];
  assign o_free     = DEPTH[AW:0] - used;
  assign wr_en      = i_wr_valid & ~full;
  assign rd_en      = i_rd_ready & ~empty;

  always @(posedge i_sys_clk) begin
    if (wr_en) begin
      mem[wp_r[AW-1:0]] <= i_wr_data;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (wr_en) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd_en) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// File: rtl/trf_sync.v
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs are static or slow levels
// Notes:   first stage feeds only the second
module trf_sync #(
  parameter N = 1
) (
  input  wire         i_sys_clk,
  input  wire         i_rst,
  input  wire [N-1:0] i_async,
  output wire [N-1:0] o_sync
);
  reg [N-1:0] meta_r;
  reg [N-1:0] sync_r;

  assign o_sync = sync_r;

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_r <= {N{1'b0}};
      sync_r <= {N{1'b0}};
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
endmodule

// File: rtl/trf_framer.v
// Purpose: builds pressed and release touch reports and sends them as bytes
// Assumes: touch samples come from same-clock logic; pins pass a synchroniser
// Notes:   a frame is only started when the FIFO has room for all of it,
//          counting the byte still on its way in
//          frame rate follows the sampler; the menu only blocks new frames
//          a release that finds the FIFO full waits for a later released sample, so keep it drained
`include "trf_map.vh"
module trf_framer #(
  parameter CW    = `TRF_COORD_W,
  parameter DEPTH = `TRF_FIFO_DEPTH,
  parameter AW    = 4
) (
  input  wire          i_sys_clk,
  input  wire          i_rst,
  input  wire          i_sample_valid,
  input  wire          i_pressed,
  input  wire [CW-1:0] i_x,
  input  wire [CW-1:0] i_y,
  input  wire          i_touch_link_select_switch,
  input  wire          i_on_screen_setup_menu,
  output wire [7:0]    o_tx_data,
  output wire          o_usb_valid,
  input  wire          i_usb_ready,
  output wire          o_uart_valid,
  input  wire          i_uart_ready,
  output wire          o_use_usb,
  output wire          o_busy
);
  localparam S_IDLE = 3'h0;
  localparam S_HDR  = 3'h1;
  localparam S_XH   = 3'h2;
  localparam S_XL   = 3'h3;
  localparam S_YH   = 3'h4;
  localparam S_YL   = 3'h5;
  localparam S_REL  = 3'h6;

  wire [1:0]  pins_s;
  wire        menu_s;
  wire        sel_s;
  wire [AW:0] free;
  wire        f_ready;
  wire [7:0]  f_rd_data;
  wire        f_rd_valid;
  wire        link_ready;

  reg [2:0]    state_r;
  reg [2:0]    state_nxt;
  reg [CW-1:0] x_r;
  reg [CW-1:0] y_r;
  reg          was_pressed_r;
  reg          use_usb_r;
  reg          strap_done_r;
  reg [3:0]    strap_cnt_r;
  reg [7:0]    byte_nxt;
  reg          push;
  reg [7:0]    tx_data_r;
  reg          tx_valid_r;

  trf_sync #(
    .N (2)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   ({i_touch_link_select_switch, i_on_screen_setup_menu}),
    .o_sync    (pins_s)
  );

  assign sel_s  = pins_s[1];
  assign menu_s = pins_s[0];

  // Switch captured once, after the synchroniser has settled
  wire strap_hit;

  assign strap_hit = ~strap_done_r & (strap_cnt_r == `TRF_STRAP_DLY);

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      strap_cnt_r <= 4'h0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 4'h1;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      strap_done_r <= 1'b0;
      use_usb_r    <= 1'b0;
    end else if (strap_hit) begin
      strap_done_r <= 1'b1;
      use_usb_r    <= sel_s;
    end
  end

  assign o_use_usb = use_usb_r;

  // Byte pushed last cycle is not yet counted in free
  wire [AW:0] inflight;
  wire [AW:0] need_frame;
  wire [AW:0] need_rel;
  wire        room_frame;
  wire        room_rel;
  wire        take_ok;
  wire        start_frame;
  wire        start_rel;

  assign inflight    = {{AW{1'b0}}, tx_valid_r};
  assign need_frame  = {{(AW-2){1'b0}}, `TRF_FRAME_BYTES} + inflight;
  assign need_rel    = {{(AW-2){1'b0}}, `TRF_REL_BYTES} + inflight;
  assign room_frame  = (free >= need_frame);
  assign room_rel    = (free >= need_rel);
  assign take_ok     = strap_done_r & i_sample_valid & ~menu_s;
  assign start_frame = (state_r == S_IDLE) & (state_nxt == S_HDR);
  assign start_rel   = (state_r == S_IDLE) & (state_nxt == S_REL);

  // Byte image of each axis: padded high byte, then low byte
  wire [CW-1:0] axis_val [0:`TRF_AXES-1];
  wire [7:0]    axis_hi  [0:`TRF_AXES-1];
  wire [7:0]    axis_lo  [0:`TRF_AXES-1];

  assign axis_val[`TRF_AXIS_X] = x_r;
  assign axis_val[`TRF_AXIS_Y] = y_r;

  genvar ax;
  generate
    for (ax = 0; ax < `TRF_AXES; ax = ax + 1) begin : g_axis
      assign axis_hi[ax] = {{(`TRF_BYTE_W+`TRF_BYTE_W-CW){1'b0}},
                            axis_val[ax][CW-1:`TRF_BYTE_W]};
      assign axis_lo[ax] = axis_val[ax][`TRF_BYTE_W-1:0];
    end
  endgenerate

  // Frame engine: starts only with room for a whole frame
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (take_ok && i_pressed && room_frame) begin
          state_nxt = S_HDR;
        end else if (take_ok && !i_pressed && was_pressed_r && room_rel) begin
          state_nxt = S_REL;
        end
      end
      S_HDR: begin
        state_nxt = S_XH;
      end
      S_XH: begin
        state_nxt = S_XL;
      end
      S_XL: begin
        state_nxt = S_YH;
      end
      S_YH: begin
        state_nxt = S_YL;
      end
      S_YL: begin
        state_nxt = S_IDLE;
      end
      S_REL: begin
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Byte for the slot now being built
  always @* begin
    byte_nxt = 8'h00;
    push     = 1'b1;
    case (state_r)
      S_HDR: begin
        byte_nxt = `TRF_HDR_PRESSED;
      end
      S_XH: begin
        byte_nxt = axis_hi[`TRF_AXIS_X];
      end
      S_XL: begin
        byte_nxt = axis_lo[`TRF_AXIS_X];
      end
      S_YH: begin
        byte_nxt = axis_hi[`TRF_AXIS_Y];
      end
      S_YL: begin
        byte_nxt = axis_lo[`TRF_AXIS_Y];
      end
      S_REL: begin
        byte_nxt = `TRF_HDR_RELEASED;
      end
      default: begin
        push = 1'b0;
      end
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_data_r  <= 8'h00;
      tx_valid_r <= 1'b0;
    end else begin
      tx_data_r  <= byte_nxt;
      tx_valid_r <= push;
    end
  end

  // Coordinates held for the whole frame
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      x_r <= {CW{1'b0}};
      y_r <= {CW{1'b0}};
    end else if (start_frame) begin
      // 10-bit values, origin upper left, taken as the panel reports them
      x_r <= i_x;
      y_r <= i_y;
    end
  end

  // A release is owed only after a pressed frame
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      was_pressed_r <= 1'b0;
    end else if (start_frame) begin
      was_pressed_r <= 1'b1;
    end else if (start_rel) begin
      was_pressed_r <= 1'b0;
    end
  end

  trf_fifo #(
    .W     (`TRF_BYTE_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_wr_data  (tx_data_r),
    .i_wr_valid (tx_valid_r),
    .o_wr_ready (f_ready),
    .o_rd_data  (f_rd_data),
    .o_rd_valid (f_rd_valid),
    .i_rd_ready (link_ready),
    .o_free     (free)
  );

  // One lane per link; only the latched one drains the FIFO
  wire [`TRF_LINKS-1:0] lane_sel;
  wire [`TRF_LINKS-1:0] lane_ready;
  wire [`TRF_LINKS-1:0] lane_valid;

  assign lane_sel   = {use_usb_r, ~use_usb_r};
  assign lane_ready = {i_usb_ready, i_uart_ready};

  genvar ln;
  generate
    for (ln = 0; ln < `TRF_LINKS; ln = ln + 1) begin : g_lane
      assign lane_valid[ln] = f_rd_valid & lane_sel[ln];
    end
  endgenerate

  assign link_ready   = |(lane_ready & lane_sel);
  assign o_usb_valid  = lane_valid[`TRF_LANE_USB];
  assign o_uart_valid = lane_valid[`TRF_LANE_UART];
  assign o_tx_data    = f_rd_data;
  assign o_busy       = (state_r != S_IDLE) | tx_valid_r | ~f_ready;
endmodule

// File: tb/trf_framer_sva.sv
// Purpose: port assertions for the touch report framer
// Assumes: one clock, reset high
// Notes:   pos_r follows the byte slot of a frame on the link
module trf_framer_sva (
  input logic       i_sys_clk,
  input logic       i_rst,
  input logic [7:0] o_tx_data,
  input logic       o_usb_valid,
  input logic       i_usb_ready,
  input logic       o_uart_valid,
  input logic       i_uart_ready,
  input logic       o_use_usb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sv;
  logic       pop;
  logic [2:0] pos_r;
  logic [4:0] age_r;
  always @(posedge i_sys_clk) begin
    if (i_rst)
      age_r <= 5'h0;
    else if (age_r != 5'h1F)
      age_r <= age_r + 5'h1;
  end
  assign sv  = o_use_usb ? o_usb_valid : o_uart_valid;
  assign pop = sv && (o_use_usb ? i_usb_ready : i_uart_ready);
  always @(posedge i_sys_clk) begin
    if (i_rst)
      pos_r <= 3'h0;
    else if (pop)
      pos_r <= (pos_r == 3'h0) ? {2'h0, o_tx_data == 8'h11} : (pos_r == 3'h4) ? 3'h0 : pos_r + 3'h1;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  link_excl_a: assert property (!(o_usb_valid && o_uart_valid)) else $error("both links valid");
  usb_route_a: assert property (o_usb_valid |-> o_use_usb) else $error("usb valid off usb");
  uart_route_a: assert property (o_uart_valid |-> !o_use_usb) else $error("uart valid on usb");
  strap_hold_a: assert property (age_r > 5'h11 |-> $stable(o_use_usb)) else $error("select moved");
  byte_hold_a: assert property (sv && !pop |=> sv && $stable(o_tx_data))
    else $error("byte not held");
  header_val_a: assert property (pop && pos_r == 3'h0 |-> o_tx_data inside {8'h11, 8'h10})
    else $error("bad header");
  high_zero_a: assert property (pop && pos_r[0] |-> o_tx_data[7:2] == 6'h0)
    else $error("high bits set");
  frame_gap_a: assert property (pos_r != 3'h0 |-> sv) else $error("gap in frame");
endmodule

// File: tb/trf_host_model.sv
// Purpose: host receiver, parses reports into records
// Assumes: i_hold stalls the ready line
// Notes:   record is header then four bytes for 11h, header alone otherwise
module trf_host_model (
  input  logic       i_sys_clk,
  input  logic       i_rst,
  input  logic       i_valid,
  input  logic [7:0] i_data,
  input  logic       i_hold,
  output logic       o_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] rec_q[$];
  logic [39:0] acc;
  int          need = 0;
  always @(posedge i_sys_clk) begin
    o_ready <= !i_hold && !i_rst;
    if (i_valid && o_ready && need > 0) begin
      acc[8*need-1 -: 8] = i_data;
      need = need - 1;
      if (need == 0) rec_q.push_back(acc);
    end else if (i_valid && o_ready) begin
      acc = {i_data, 32'h0};
      need = (i_data == 8'h11) ? 4 : 0;
      if (need == 0) rec_q.push_back(acc);
    end
  end
endmodule

// File: tb/touch_report_framer_tb.sv
// Purpose: self-checking bench for the touch report framer
// Assumes: both links tried, one per reset
// Notes:   random values come from an LFSR
module touch_report_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, smp = 1'b0, prs = 1'b0, sw = 1'b0, menu = 1'b0;
  logic        stall = 1'b0, lnk;
  logic [9:0]  xv = 10'h0, yv = 10'h0, a, b;
  logic [31:0] rnd = 32'h2946;
  logic [7:0]  tx;
  logic        usb_v, uart_v, usb_r, uart_r, use_usb, busy;
  logic [39:0] exp_q[$];
  int          error_cnt = 0, check_count = 0;
  initial forever #2 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [39:0] frame(input logic p, input logic [9:0] x, input logic [9:0] y);
    frame = p ? {8'h11, 6'h0, x, 6'h0, y} : {8'h10, 32'h0};
  endfunction
  always @(posedge clk) rnd <= lfsr(rnd);
  trf_framer dut_u (.i_sys_clk(clk), .i_rst(rst), .i_sample_valid(smp), .i_pressed(prs),
    .i_x(xv), .i_y(yv), .i_touch_link_select_switch(sw), .i_on_screen_setup_menu(menu),
    .o_tx_data(tx), .o_usb_valid(usb_v), .i_usb_ready(usb_r), .o_uart_valid(uart_v),
    .i_uart_ready(uart_r), .o_use_usb(use_usb), .o_busy(busy));
  trf_host_model host_u (.i_sys_clk(clk), .i_rst(rst), .i_valid(usb_v), .i_data(tx),
    .i_hold(stall || rnd[1:0] == 2'h3), .o_ready(usb_r));
  trf_host_model host_s (.i_sys_clk(clk), .i_rst(rst), .i_valid(uart_v), .i_data(tx),
    .i_hold(stall || rnd[3:2] == 2'h3), .o_ready(uart_r));
  task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task send(input logic p, input logic [9:0] x, input logic [9:0] y, input bit keep);
    @(posedge clk);
    smp <= 1'b1;
    prs <= p;
    xv <= x;
    yv <= y;
    @(posedge clk);
    smp <= 1'b0;
    if (keep) exp_q.push_back(frame(p, x, y));
    repeat (8) @(posedge clk);
  endtask
  task drain;
    logic [39:0] g;
    for (int n = 0; n < 400 && (lnk ? host_u.rec_q.size() : host_s.rec_q.size()) < exp_q.size(); n++)
      @(posedge clk);
    while (exp_q.size() > 0) begin
      g = 40'hX;
      if (lnk && host_u.rec_q.size() > 0) g = host_u.rec_q.pop_front();
      if (!lnk && host_s.rec_q.size() > 0) g = host_s.rec_q.pop_front();
      chk("report", exp_q.pop_front(), g);
    end
    chk("stray", 40'h0, 40'(host_u.rec_q.size() + host_s.rec_q.size()));
  endtask
  task complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run;
  end
  initial begin
    for (int ph = 0; ph < 2; ph++) begin
      lnk = ph[0];
      sw <= lnk;
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      chk("reset idle", 40'h0, {36'h0, use_usb, usb_v, uart_v, busy});
      rst <= 1'b0;
      repeat (20) @(posedge clk);
      sw <= !lnk;
      send(1'b1, 10'h0, 10'h0, 1'b1);
      send(1'b1, 10'h3FF, 10'h3FF, 1'b1);
      for (int k = 0; k < 4; k++) begin
        a = rnd[9:0];
        b = rnd[25:16];
        send(1'b1, a, b, 1'b1);
        send(1'b1, a, b, 1'b1);
      end
      send(1'b0, a, b, 1'b1);
      send(1'b0, a, b, 1'b0);
      menu <= 1'b1;
      repeat (3) @(posedge clk);
      send(1'b1, a, b, 1'b0);
      menu <= 1'b0;
      repeat (3) @(posedge clk);
      stall <= 1'b1;
      for (int k = 0; k < 4; k++) send(1'b1, rnd[9:0], rnd[21:12], k < 3);
      send(1'b0, a, b, 1'b1);
      chk("fifo full", 40'h1, {39'h0, busy});
      stall <= 1'b0;
      drain;
      chk("idle busy", 40'h0, {39'h0, busy});
      chk("link select", {39'h0, lnk}, {39'h0, use_usb});
    end
    complete_run;
  end
endmodule
bind trf_framer trf_framer_sva chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_tx_data(o_tx_data),
  .o_usb_valid(o_usb_valid), .i_usb_ready(i_usb_ready), .o_uart_valid(o_uart_valid),
  .i_uart_ready(i_uart_ready), .o_use_usb(o_use_usb));
